//--- qsrw_pkg.sv
// Behaviour
// - Four channels, each drives active-low fault output.
// - Output held for per-channel delay after recovery.
// - Channel four faults when low monitor drops.
// - Channel four faults when high monitor exceeds.
// - Channel four combines both comparators into one.
// - Open or pulled-up select gives fixed delay.
// - Capacitor select gives programmed delay setting.
// - Output low in fault, high after delay.
// - Output stays low throughout fault and delay.
// - Either kick edge restarts the watchdog period.
// - Watchdog starts when channel one releases.
// - Watchdog expiry drives timeout output low.
// - Timeout output high while no expiry.
package qsrw_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CLOCK_HZ         = 100_000_000;
  localparam int unsigned FIXED_DELAY_US   = 20_000;
  localparam int unsigned MIN_DELAY_US     = 1_400;
  localparam int unsigned WATCHDOG_MS      = 610;
  localparam int unsigned FIXED_DELAY_CYC  = FIXED_DELAY_US * (CLOCK_HZ / 1_000_000);
  localparam int unsigned MIN_DELAY_CYC    = MIN_DELAY_US * (CLOCK_HZ / 1_000_000);
  localparam int unsigned WATCHDOG_CYC     = WATCHDOG_MS * (CLOCK_HZ / 1_000);

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int unsigned CHANNELS         = 4;
  localparam int unsigned DELAY_W          = 30;
  localparam int unsigned SYNC_STAGES      = 2;

  typedef enum logic [1:0] {
    QSRW_IDLE,
    QSRW_FAULT,
    QSRW_DELAY
  } qsrw_chan_state_t;

endpackage : qsrw_pkg

//--- qsrw_channel.sv
`timescale 1ns/10ps
`default_nettype none
module qsrw_channel
  import qsrw_pkg::*;
(
  input  wire logic               clock_in,
  input  wire logic               rst_n_in,
  input  wire logic               fault_in,
  input  wire logic [DELAY_W-1:0] delay_cycles_in,
  output logic                    fault_out_n
);

  qsrw_chan_state_t   state_reg;
  qsrw_chan_state_t   state_next;
  logic [DELAY_W-1:0] count_reg;
  logic [DELAY_W-1:0] count_next;
  wire                delay_done;

  assign delay_done = (count_reg >= delay_cycles_in - DELAY_W'(1));

  always_comb begin
    state_next = state_reg;
    count_next = count_reg;
    case (state_reg)
      QSRW_IDLE: begin
        if (fault_in) begin
          state_next = QSRW_FAULT;
        end
      end
      QSRW_FAULT: begin
        count_next = '0;
        if (!fault_in) begin
          state_next = QSRW_DELAY;
        end
      end
      QSRW_DELAY: begin
        if (fault_in) begin
          state_next = QSRW_FAULT;
          count_next = '0;
        end else if (delay_done) begin
          state_next = QSRW_IDLE;
        end else begin
          count_next = count_reg + DELAY_W'(1);
        end
      end
      default: begin
        state_next = QSRW_FAULT;
      end
    endcase
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_reg   <= QSRW_FAULT;
      count_reg   <= '0;
      fault_out_n <= 1'b0;
    end else begin
      state_reg   <= state_next;
      count_reg   <= count_next;
      fault_out_n <= (state_next == QSRW_IDLE);
    end
  end

endmodule : qsrw_channel
`default_nettype wire

//--- quad_supply_reset_watchdog.sv
`timescale 1ns/10ps
`default_nettype none
module quad_supply_reset_watchdog
  import qsrw_pkg::*;
(
  input  wire logic                  clock_in,
  input  wire logic                  supply_fault_out_n_in,
  input  wire logic [CHANNELS-2:0]   rail_monitor_in,
  input  wire logic                  window_low_monitor_in,
  input  wire logic                  window_high_monitor_in,
  input  wire logic                  manual_fault_request_n,
  input  wire logic                  watchdog_kick_in,
  input  wire logic [CHANNELS-1:0]   release_delay_select,
  input  wire logic [DELAY_W-1:0]    delay_setting_in [CHANNELS],
  output logic      [CHANNELS-1:0]   supply_fault_out_n,
  output logic                       watchdog_timeout_out_n
);

  // ****************************************************************
  // Reset release and input synchronisers
  // ****************************************************************
  localparam int unsigned SYNC_W = 7;
  // The manual request idles high, so its synchroniser resets high to avoid a false request.
  localparam logic [SYNC_W-1:0] SYNC_RESET = 7'h20;

  logic [1:0]        rst_sync_reg;
  wire               rst_n;
  wire  [SYNC_W-1:0] raw_inputs;
  logic [SYNC_W-1:0] meta_reg;
  logic [SYNC_W-1:0] sync_reg;

  assign rst_n = rst_sync_reg[1];

  always_ff @(posedge clock_in or negedge supply_fault_out_n_in) begin
    if (!supply_fault_out_n_in) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end

  // Input levels: in the low five bits, 1 means under or over voltage on the rail.
  assign raw_inputs = {watchdog_kick_in,
                       manual_fault_request_n,
                       window_high_monitor_in,
                       ~window_low_monitor_in,
                       ~rail_monitor_in};

  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= SYNC_RESET;
      sync_reg <= SYNC_RESET;
    end else begin
      meta_reg <= raw_inputs;
      sync_reg <= meta_reg;
    end
  end

  // ****************************************************************
  // Fault decisions
  // ****************************************************************
  wire [CHANNELS-2:0] rail_low_sync;
  wire                window_low_sync;
  wire                window_high_sync;
  wire                manual_request_sync;
  wire                kick_sync;
  wire                window_fault;
  wire [CHANNELS-1:0] chan_fault;

  assign rail_low_sync       = sync_reg[2:0];
  assign window_low_sync     = sync_reg[3];
  assign window_high_sync    = sync_reg[4];
  assign manual_request_sync = ~sync_reg[5];
  assign kick_sync           = sync_reg[6];

  // Either side of the window faults the channel; no hysteresis is added here.
  assign window_fault  = window_low_sync | window_high_sync;
  assign chan_fault[0] = rail_low_sync[0] | manual_request_sync;
  assign chan_fault[1] = rail_low_sync[1];
  assign chan_fault[2] = rail_low_sync[2];
  assign chan_fault[3] = window_fault;

  // ****************************************************************
  // Channels
  // ****************************************************************
  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch++) begin : g_chan
      wire [DELAY_W-1:0] delay_cycles;
      wire [DELAY_W-1:0] programmed;

      // Short programmed settings are lifted to the least documented delay.
      assign programmed   = (delay_setting_in[ch] < DELAY_W'(MIN_DELAY_CYC)) ?
                            DELAY_W'(MIN_DELAY_CYC) : delay_setting_in[ch];
      assign delay_cycles = release_delay_select[ch] ? DELAY_W'(FIXED_DELAY_CYC) : programmed;

      qsrw_channel u_chan (
        .clock_in        (clock_in),
        .rst_n_in        (rst_n),
        .fault_in        (chan_fault[ch]),
        .delay_cycles_in (delay_cycles),
        .fault_out_n     (supply_fault_out_n[ch])
      );
    end
  endgenerate

  // ****************************************************************
  // Watchdog
  // ****************************************************************
  logic [DELAY_W-1:0] wd_count_reg;
  logic               kick_prev_reg;
  wire                kick_edge;
  wire                wd_expired;

  assign kick_edge  = kick_sync ^ kick_prev_reg;
  assign wd_expired = (wd_count_reg >= DELAY_W'(WATCHDOG_CYC - 1));

  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      wd_count_reg           <= '0;
      kick_prev_reg          <= 1'b0;
      watchdog_timeout_out_n <= 1'b1;
    end else begin
      kick_prev_reg <= kick_sync;
      if (!supply_fault_out_n[0] || kick_edge) begin
        wd_count_reg           <= '0;
        watchdog_timeout_out_n <= 1'b1;
      end else if (wd_expired) begin
        watchdog_timeout_out_n <= 1'b0;
      end else begin
        wd_count_reg <= wd_count_reg + DELAY_W'(1);
      end
    end
  end

endmodule : quad_supply_reset_watchdog
`default_nettype wire

//--- qsrw_properties.sv
`timescale 1ns/10ps
`default_nettype none
module qsrw_properties
  import qsrw_pkg::*;
(
  input wire logic                clock_in,
  input wire logic                supply_fault_out_n_in,
  input wire logic [CHANNELS-2:0] rail_monitor_in,
  input wire logic                window_low_monitor_in,
  input wire logic                window_high_monitor_in,
  input wire logic                manual_fault_request_n,
  input wire logic                watchdog_kick_in,
  input wire logic [CHANNELS-1:0] release_delay_select,
  input wire logic [CHANNELS-1:0] supply_fault_out_n,
  input wire logic                watchdog_timeout_out_n
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!supply_fault_out_n_in);
  logic [3:0]  ok;
  int unsigned run [4];
  assign ok = {window_low_monitor_in & ~window_high_monitor_in, rail_monitor_in[2:1],
               rail_monitor_in[0] & manual_fault_request_n};
  // Counting raw good time overstates the synced wait, so a release may never beat it.
  always_ff @(posedge clock_in) begin
    for (int i = 0; i < 4; i++) begin
      run[i] <= ok[i] ? run[i] + 1 : 0;
    end
  end
  property p_flt(logic c, int i);
    c |-> ##[1:5] !supply_fault_out_n[i];
  endproperty
  property p_rel(int i);
    $rose(supply_fault_out_n[i]) |-> run[i] >= (release_delay_select[i] ? FIXED_DELAY_CYC : MIN_DELAY_CYC);
  endproperty
  AST_FLT0: assert property (p_flt(!rail_monitor_in[0], 0)) else $error("fault late");
  AST_MAN: assert property (p_flt(!manual_fault_request_n, 0)) else $error("manual late");
  AST_WLO: assert property (p_flt(!window_low_monitor_in, 3)) else $error("low late");
  AST_WHI: assert property (p_flt(window_high_monitor_in, 3)) else $error("high late");
  AST_REL0: assert property (p_rel(0)) else $error("early release");
  AST_REL1: assert property (p_rel(1)) else $error("early release");
  AST_WDF: assert property (!supply_fault_out_n[0] |-> ##[0:2] watchdog_timeout_out_n) else $error("wd");
  AST_KICK: assert property ($changed(watchdog_kick_in) |-> ##[1:5] watchdog_timeout_out_n) else $error("k");
  cover property ($rose(supply_fault_out_n[1]));
  cover property ($fell(supply_fault_out_n[3]));
  cover property ($changed(watchdog_kick_in) && supply_fault_out_n[0]);
endmodule : qsrw_properties
`default_nettype wire

//--- qsrw_partner_model.sv
`timescale 1ns/10ps
`default_nettype none
module qsrw_partner_model (
  input  wire logic       clock_in,
  input  wire logic [4:0] rail_cmd_in,
  output logic      [4:0] rail_out,
  output logic            kick_out
);
  logic [15:0] cnt = 16'h0000;
  // Rails are always driven comparator levels, never released.
  assign rail_out = rail_cmd_in;
  assign kick_out = cnt[9];
  always @(negedge clock_in) begin
    cnt <= cnt + 16'h0001;
  end
endmodule : qsrw_partner_model
`default_nettype wire

//--- tb_quad_supply_reset_watchdog.sv
`timescale 1ns/10ps
`default_nettype none
module tb_quad_supply_reset_watchdog;
  import qsrw_pkg::*;
  logic                clock_in = 1'b0;
  logic                supply_fault_out_n_in = 1'b0;
  logic                mr_n = 1'b1;
  logic [4:0]          rail_cmd = 5'h0F;
  logic [4:0]          rails;
  logic                kick;
  logic [4:0]          seen;
  logic [CHANNELS-1:0] sel = 4'h4;
  logic [DELAY_W-1:0]  dly [CHANNELS] = '{30'h64, 30'h249F0, 30'h222E0, 30'h222E0};
  int                  fail_count = 0;
  int                  check_count = 0;
  quad_supply_reset_watchdog u_dut (.clock_in, .supply_fault_out_n_in, .rail_monitor_in(rails[2:0]),
    .window_low_monitor_in(rails[3]), .window_high_monitor_in(rails[4]), .manual_fault_request_n(mr_n),
    .watchdog_kick_in(kick), .release_delay_select(sel), .delay_setting_in(dly),
    .supply_fault_out_n(seen[3:0]), .watchdog_timeout_out_n(seen[4]));
  qsrw_partner_model u_far (.clock_in, .rail_cmd_in(rail_cmd), .rail_out(rails), .kick_out(kick));
  initial forever #5 clock_in = ~clock_in;
  task automatic cyc(input int n);
    repeat (n) @(negedge clock_in);
  endtask : cyc
  task automatic chk(input logic [4:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value outputs expected %h seen %h", exp, seen);
    end
  endtask : chk
  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : finish_test
  task automatic t_release;
    cyc(139986);
    chk(5'h10);
    cyc(30);
    chk(5'h19);
    cyc(10000);
    chk(5'h1B);
    $display("release test done");
  endtask : t_release
  task automatic t_causes;
    rail_cmd = 5'h1F;
    cyc(6);
    chk(5'h13);
    rail_cmd = 5'h0F;
    mr_n = 1'b0;
    cyc(6);
    chk(5'h12);
    mr_n = 1'b1;
    rail_cmd = 5'h0D;
    cyc(6);
    chk(5'h10);
    rail_cmd = 5'h0F;
    $display("cause test done");
  endtask : t_causes
  // A short dip mid-delay must restart the wait from scratch.
  task automatic t_refault;
    cyc(100000);
    rail_cmd = 5'h04;
    cyc(3);
    rail_cmd = 5'h0F;
    cyc(40015);
    chk(5'h10);
    cyc(100006);
    chk(5'h19);
    $display("refault test done");
  endtask : t_refault
  initial begin
    cyc(8);
    supply_fault_out_n_in = 1'b1;
    t_release;
    t_causes;
    t_refault;
    finish_test;
  end
  initial begin
    #5_000_000;
    fail_count++;
    finish_test;
  end
endmodule : tb_quad_supply_reset_watchdog
bind quad_supply_reset_watchdog qsrw_properties u_props (.clock_in, .supply_fault_out_n_in, .rail_monitor_in,
  .window_low_monitor_in, .window_high_monitor_in, .manual_fault_request_n, .watchdog_kick_in,
  .release_delay_select, .supply_fault_out_n, .watchdog_timeout_out_n);
`default_nettype wire
